// >>> include/vta_pkg.sv
package vta_pkg;

  // Table geometry
  localparam int unsigned IDX_W   = 12;
  localparam int unsigned DEPTH   = 4096;
  localparam int unsigned PORTS   = 7;
  localparam int unsigned ADDR_W  = 16;
  localparam int unsigned DATA_W  = 8;

  // Byte addresses of the access port registers
  localparam logic [15:0] OFS_ENTRY_WORD0   = 16'h0400;
  localparam logic [15:0] OFS_ENTRY_UNTAG   = 16'h0404;
  localparam logic [15:0] OFS_ENTRY_FORWARD = 16'h0408;
  localparam logic [15:0] OFS_SELECTOR      = 16'h040C;
  localparam logic [15:0] OFS_COMMAND       = 16'h040E;

  // Writable bits of each register; everything else reads zero
  localparam logic [31:0] MASK_WORD0    = 32'h8F00707F;
  localparam logic [31:0] MASK_PORT_MAP = 32'h0000007F;
  localparam logic [15:0] MASK_SELECTOR = 16'h0FFF;

  // Reset values
  localparam logic [31:0] RST_WORD      = 32'h00000000;
  localparam logic [15:0] RST_SELECTOR  = 16'h0000;
  localparam logic [IDX_W-1:0] RST_INDEX = 12'h000;

  // Field positions in the first entry register
  localparam int unsigned VALID_BIT = 31;
  localparam int unsigned FO_BIT    = 27;
  localparam int unsigned PRIO_HI   = 26;
  localparam int unsigned PRIO_LO   = 24;
  localparam int unsigned STI_HI    = 14;
  localparam int unsigned STI_LO    = 12;
  localparam int unsigned FID_HI    = 6;
  localparam int unsigned FID_LO    = 0;

  // Field positions in the command byte
  localparam int unsigned START_BIT = 7;
  localparam int unsigned ACT_HI    = 1;
  localparam int unsigned ACT_LO    = 0;

  // Byte lanes inside the word at the selector address
  localparam logic [1:0] LANE_SEL_HI = 2'h0;
  localparam logic [1:0] LANE_SEL_LO = 2'h1;
  localparam logic [1:0] LANE_CMD    = 2'h2;

  localparam logic [7:0] BYTE_ZERO = 8'h00;

  // Last entry visited by a clear-all sweep
  localparam logic [IDX_W-1:0] LAST_INDEX = 12'hFFF;

  typedef enum logic [1:0]
  {
    ACT_NOP   = 2'h0,
    ACT_WRITE = 2'h1,
    ACT_READ  = 2'h2,
    ACT_CLEAR = 2'h3
  } vta_action_t;

  typedef enum logic [1:0]
  {
    ST_IDLE      = 2'h0,
    ST_READ_LOAD = 2'h1,
    ST_CLEAR     = 2'h2
  } vta_state_t;

  // One stored table entry
  typedef struct packed
  {
    logic             valid;
    logic             port_map_override;
    logic [2:0]       priority_level;
    logic [2:0]       spanning_instance_number;
    logic [6:0]       filter_identifier;
    logic [PORTS-1:0] untag_map;
    logic [PORTS-1:0] forward_map;
  } vta_entry_t;

  localparam vta_entry_t ENTRY_ZERO = '0;

endpackage

// >>> hw/vta_mem.sv
`timescale 1ns/1ns
// Table storage: one write port, two registered read ports
module vta_mem
  import vta_pkg::*;
(
  input  wire logic                      ref_clk_in,
  input  wire logic                      wr_en_in,
  input  wire logic [vta_pkg::IDX_W-1:0] wr_addr_in,
  input  vta_pkg::vta_entry_t            wr_data_in,
  input  wire logic [vta_pkg::IDX_W-1:0] rd_a_addr_in,
  output vta_pkg::vta_entry_t            rd_a_data_out,
  input  wire logic [vta_pkg::IDX_W-1:0] rd_b_addr_in,
  output vta_pkg::vta_entry_t            rd_b_data_out
);

  vta_entry_t mem [DEPTH];

  // No reset on the array; software clears it with the clear-all action
  always_ff @(posedge ref_clk_in)
  begin
    if (wr_en_in)
    begin
      mem[wr_addr_in] <= wr_data_in;
    end
    rd_a_data_out <= mem[rd_a_addr_in];
    rd_b_data_out <= mem[rd_b_addr_in];
  end

endmodule

// >>> hw/vta_lookup.sv
`timescale 1ns/1ns
// Registers the looked-up entry and resolves the egress map
module vta_lookup
  import vta_pkg::*;
(
  input  wire logic                      ref_clk_in,
  input  wire logic                      rst_in,
  input  vta_pkg::vta_entry_t            entry_in,
  input  wire logic [vta_pkg::PORTS-1:0] other_map_in,
  output logic                           valid_out,
  output logic                           override_out,
  output logic [2:0]                     priority_out,
  output logic [2:0]                     spanning_out,
  output logic [6:0]                     filter_out,
  output logic [vta_pkg::PORTS-1:0]      untag_out,
  output logic [vta_pkg::PORTS-1:0]      egress_map_out
);

  logic [PORTS-1:0] next_egress_map;

  // Per port: own forward mask under override, otherwise the outside map
  for (genvar p = 0; p < PORTS; p++)
  begin : g_port
    always_comb
    begin
      next_egress_map[p] = entry_in.port_map_override ? entry_in.forward_map[p]
                                                      : other_map_in[p];
    end
  end

  always_ff @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      valid_out      <= 1'b0;
      override_out   <= 1'b0;
      priority_out   <= '0;
      spanning_out   <= '0;
      filter_out     <= '0;
      untag_out      <= '0;
      egress_map_out <= '0;
    end
    else
    begin
      valid_out      <= entry_in.valid;
      override_out   <= entry_in.port_map_override;
      priority_out   <= entry_in.priority_level;
      spanning_out   <= entry_in.spanning_instance_number;
      filter_out     <= entry_in.filter_identifier;
      untag_out      <= entry_in.untag_map;
      egress_map_out <= next_egress_map;
    end
  end

endmodule

// >>> hw/vta_access.sv
`timescale 1ns/1ns
// Functional notes
// - Bit 31 of the first entry register is the entry valid flag, 1 valid and 0 invalid.
// - An entry with bit 27 set forwards to its own forward mask, otherwise other sources decide.
// - Bits 26:24 of the first entry register hold the entry's three-bit priority.
// - Bits 14:12 of the first entry register hold the spanning tree instance number.
// - Bits 6:0 of the first entry register hold the seven-bit filter identifier.
// - The second entry register's bits 6:0 are the untag mask for ports 1 to 7.
// - The third entry register's bits 6:0 are the forward mask for ports 1 to 7, used under override.
// - The selector register's bits 11:0 pick the entry, and bits 15:12 read zero.
// - Writing 1 to command bit 7 starts the action, and the device clears it when done.
// - Action 00 does nothing, 01 writes the indexed entry and 10 reads it.
// - Action 11 sets every table entry to zero whatever the selector holds.
module vta_access
  import vta_pkg::*;
(
  input  wire logic                       ref_clk_in,
  input  wire logic                       rst_in,
  input  wire logic [vta_pkg::ADDR_W-1:0] reg_addr_in,
  input  wire logic                       reg_wr_in,
  input  wire logic [vta_pkg::DATA_W-1:0] reg_wdata_in,
  input  wire logic                       reg_rd_in,
  output logic [vta_pkg::DATA_W-1:0]      reg_rdata_out,
  output logic                            reg_rvalid_out,
  output logic                            busy_out,
  input  wire logic [vta_pkg::IDX_W-1:0]  lookup_index_in,
  input  wire logic [vta_pkg::PORTS-1:0]  lookup_other_map_in,
  output logic                            lookup_valid_out,
  output logic                            lookup_override_out,
  output logic [2:0]                      lookup_priority_out,
  output logic [2:0]                      lookup_spanning_out,
  output logic [6:0]                      lookup_filter_out,
  output logic [vta_pkg::PORTS-1:0]       lookup_untag_out,
  output logic [vta_pkg::PORTS-1:0]       lookup_egress_map_out
);

  // Big-endian byte order: lane 0 is bits 31:24
  function automatic logic [7:0] get_byte(input logic [31:0] word, input logic [1:0] lane);
    logic [4:0] shift;
    shift = {~lane, 3'b000};
    return word[shift +: 8];
  endfunction

  function automatic logic [31:0] put_byte(input logic [31:0] word, input logic [1:0] lane,
                                           input logic [7:0] data);
    logic [31:0] result;
    logic [4:0]  shift;
    result = word;
    shift = {~lane, 3'b000};
    result[shift +: 8] = data;
    return result;
  endfunction

  // Word hit test, shared by the read and write decoders
  function automatic logic word_hit(input logic [15:0] addr, input logic [15:0] base);
    return addr[15:2] == base[15:2];
  endfunction

  // Register state
  logic [31:0]       entry_word0;
  logic [31:0]       entry_untag;
  logic [31:0]       entry_forward;
  logic [15:0]       selector;
  vta_action_t       action;
  logic              start;
  vta_state_t        state;
  logic [IDX_W-1:0]  clear_index;

  logic [31:0]       next_entry_word0;
  logic [31:0]       next_entry_untag;
  logic [31:0]       next_entry_forward;
  logic [15:0]       next_selector;
  vta_action_t       next_action;
  logic              next_start;
  vta_state_t        next_state;
  logic [IDX_W-1:0]  next_clear_index;

  logic [7:0]        next_rdata;

  // Table port signals: write port and read port A, plus lookup_entry from read port B
  logic              mem_wr_en;
  logic [IDX_W-1:0]  mem_addr;
  vta_entry_t        mem_wr_data;
  vta_entry_t        mem_rd_data;
  vta_entry_t        lookup_entry;
  vta_entry_t        reg_entry;

  logic [1:0]        lane;
  logic [31:0]       sel_cmd_word;
  logic [31:0]       sel_cmd_merged;

  assign lane = reg_addr_in[1:0];
  assign busy_out = start;

  // Selector and command share one word so byte lanes line up with the offsets
  assign sel_cmd_word = {selector, start, 5'b00000, action, BYTE_ZERO};
  assign sel_cmd_merged = put_byte(sel_cmd_word, lane, reg_wdata_in);

  // Pack the entry registers into one stored entry
  always_comb
  begin
    reg_entry.valid                    = entry_word0[VALID_BIT];
    reg_entry.port_map_override        = entry_word0[FO_BIT];
    reg_entry.priority_level           = entry_word0[PRIO_HI:PRIO_LO];
    reg_entry.spanning_instance_number = entry_word0[STI_HI:STI_LO];
    reg_entry.filter_identifier        = entry_word0[FID_HI:FID_LO];
    reg_entry.untag_map                = entry_untag[PORTS-1:0];
    reg_entry.forward_map              = entry_forward[PORTS-1:0];
  end

  // Table write port: the clear sweep takes it over, else the selector drives it
  always_comb
  begin
    mem_wr_en   = 1'b0;
    mem_wr_data = reg_entry;
    mem_addr    = selector[IDX_W-1:0];
    if (state == ST_CLEAR)
    begin
      mem_wr_en   = 1'b1;
      mem_wr_data = ENTRY_ZERO;
      mem_addr    = clear_index;
    end
    else if (state == ST_IDLE && start && action == ACT_WRITE)
    begin
      mem_wr_en = 1'b1;
    end
  end

  // Next register values: hardware loads and the sequencer, then software writes.
  // Software writes are ignored while an action runs so the action sees
  // stable operands and a read load is never overwritten halfway.
  always_comb
  begin
    next_entry_word0   = entry_word0;
    next_entry_untag   = entry_untag;
    next_entry_forward = entry_forward;
    next_selector      = selector;
    next_action        = action;
    next_start         = start;
    next_state         = state;
    next_clear_index   = clear_index;
    case (state)
      ST_IDLE:
      begin
        if (start)
        begin
          case (action)
            ACT_NOP:
            begin
              next_start = 1'b0;
            end
            ACT_WRITE:
            begin
              next_start = 1'b0;
            end
            ACT_READ:
            begin
              next_state = ST_READ_LOAD;
            end
            ACT_CLEAR:
            begin
              next_state       = ST_CLEAR;
              next_clear_index = RST_INDEX;
            end
            default:
            begin
              next_start = 1'b0;
            end
          endcase
        end
        else if (reg_wr_in)
        begin
          if (word_hit(reg_addr_in, OFS_ENTRY_WORD0))
          begin
            next_entry_word0 = put_byte(entry_word0, lane, reg_wdata_in) & MASK_WORD0;
          end
          if (word_hit(reg_addr_in, OFS_ENTRY_UNTAG))
          begin
            next_entry_untag = put_byte(entry_untag, lane, reg_wdata_in) & MASK_PORT_MAP;
          end
          if (word_hit(reg_addr_in, OFS_ENTRY_FORWARD))
          begin
            next_entry_forward = put_byte(entry_forward, lane, reg_wdata_in) & MASK_PORT_MAP;
          end
          if (word_hit(reg_addr_in, OFS_SELECTOR))
          begin
            if (lane == LANE_SEL_HI || lane == LANE_SEL_LO)
            begin
              next_selector = sel_cmd_merged[31:16] & MASK_SELECTOR;
            end
            else if (lane == LANE_CMD)
            begin
              next_action = vta_action_t'(reg_wdata_in[ACT_HI:ACT_LO]);
              next_start  = reg_wdata_in[START_BIT];
            end
          end
        end
      end
      ST_READ_LOAD:
      begin
        // Port A data now holds the selected entry
        next_entry_word0 = RST_WORD;
        next_entry_word0[VALID_BIT]       = mem_rd_data.valid;
        next_entry_word0[FO_BIT]          = mem_rd_data.port_map_override;
        next_entry_word0[PRIO_HI:PRIO_LO] = mem_rd_data.priority_level;
        next_entry_word0[STI_HI:STI_LO]   = mem_rd_data.spanning_instance_number;
        next_entry_word0[FID_HI:FID_LO]   = mem_rd_data.filter_identifier;
        next_entry_untag = RST_WORD;
        next_entry_untag[PORTS-1:0] = mem_rd_data.untag_map;
        next_entry_forward = RST_WORD;
        next_entry_forward[PORTS-1:0] = mem_rd_data.forward_map;
        next_start = 1'b0;
        next_state = ST_IDLE;
      end
      ST_CLEAR:
      begin
        next_clear_index = clear_index + 1'b1;
        if (clear_index == LAST_INDEX)
        begin
          next_start = 1'b0;
          next_state = ST_IDLE;
        end
      end
      default:
      begin
        next_state = ST_IDLE;
        next_start = 1'b0;
      end
    endcase
  end

  always_ff @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      entry_word0   <= RST_WORD;
      entry_untag   <= RST_WORD;
      entry_forward <= RST_WORD;
      selector      <= RST_SELECTOR;
      action        <= ACT_NOP;
      start         <= 1'b0;
      state         <= ST_IDLE;
      clear_index   <= RST_INDEX;
    end
    else
    begin
      entry_word0   <= next_entry_word0;
      entry_untag   <= next_entry_untag;
      entry_forward <= next_entry_forward;
      selector      <= next_selector;
      action        <= next_action;
      start         <= next_start;
      state         <= next_state;
      clear_index   <= next_clear_index;
    end
  end

  // Read decode; unmapped addresses answer zero
  always_comb
  begin
    next_rdata = BYTE_ZERO;
    if (word_hit(reg_addr_in, OFS_ENTRY_WORD0))
    begin
      next_rdata = get_byte(entry_word0, lane);
    end
    else if (word_hit(reg_addr_in, OFS_ENTRY_UNTAG))
    begin
      next_rdata = get_byte(entry_untag, lane);
    end
    else if (word_hit(reg_addr_in, OFS_ENTRY_FORWARD))
    begin
      next_rdata = get_byte(entry_forward, lane);
    end
    else if (word_hit(reg_addr_in, OFS_SELECTOR))
    begin
      next_rdata = get_byte(sel_cmd_word, lane);
    end
  end

  always_ff @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      reg_rdata_out  <= BYTE_ZERO;
      reg_rvalid_out <= 1'b0;
    end
    else
    begin
      reg_rdata_out  <= reg_rd_in ? next_rdata : BYTE_ZERO;
      reg_rvalid_out <= reg_rd_in;
    end
  end

  vta_mem u_mem
  (
    .ref_clk_in    (ref_clk_in),
    .wr_en_in      (mem_wr_en),
    .wr_addr_in    (mem_addr),
    .wr_data_in    (mem_wr_data),
    .rd_a_addr_in  (mem_addr),
    .rd_a_data_out (mem_rd_data),
    .rd_b_addr_in  (lookup_index_in),
    .rd_b_data_out (lookup_entry)
  );

  vta_lookup u_lookup
  (
    .ref_clk_in     (ref_clk_in),
    .rst_in         (rst_in),
    .entry_in       (lookup_entry),
    .other_map_in   (lookup_other_map_in),
    .valid_out      (lookup_valid_out),
    .override_out   (lookup_override_out),
    .priority_out   (lookup_priority_out),
    .spanning_out   (lookup_spanning_out),
    .filter_out     (lookup_filter_out),
    .untag_out      (lookup_untag_out),
    .egress_map_out (lookup_egress_map_out)
  );

endmodule

// >>> test/vta_access_chk.sv
`timescale 1ns/1ns
// Watches the register port and the start flag of the access block
module vta_access_chk
  import vta_pkg::*;
(
  input wire logic                       ref_clk_in,
  input wire logic                       rst_in,
  input wire logic [vta_pkg::ADDR_W-1:0] reg_addr_in,
  input wire logic                       reg_wr_in,
  input wire logic [vta_pkg::DATA_W-1:0] reg_wdata_in,
  input wire logic                       reg_rd_in,
  input wire logic [vta_pkg::DATA_W-1:0] reg_rdata_out,
  input wire logic                       reg_rvalid_out,
  input wire logic                       busy_out
);
  import vta_pkg::*;
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);

  logic [12:0] busy_cnt;
  logic [12:0] next_busy_cnt;
  logic        go;
  logic [1:0]  act;

  // A start that the idle block must accept
  assign go = !busy_out && reg_wr_in && reg_addr_in == OFS_COMMAND && reg_wdata_in[START_BIT];
  assign act = reg_wdata_in[ACT_HI:ACT_LO];

  // Busy stretch length; saturates so a stuck flag cannot wrap back into range
  always_comb
  begin
    next_busy_cnt = 13'h0000;
    if (busy_out)
      next_busy_cnt = (busy_cnt == 13'h1FFF) ? busy_cnt : busy_cnt + 13'h0001;
  end

  // Counter register
  always_ff @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
      busy_cnt <= 13'h0000;
    else
      busy_cnt <= next_busy_cnt;
  end

  a_rvalid_after_rd: assert property (reg_rd_in |=> reg_rvalid_out)
    else $error("read strobe got no answer");
  a_rdata_idle_zero: assert property (!reg_rd_in |=> !reg_rvalid_out && reg_rdata_out == 8'h00)
    else $error("read answer without request");
  a_start_sets_busy: assert property (go |=> busy_out)
    else $error("start not taken");
  a_no_self_start: assert property (!busy_out && !go |=> !busy_out)
    else $error("busy rose without start");
  a_short_action_done: assert property (go && act inside {ACT_NOP, ACT_WRITE}
    |=> busy_out ##1 !busy_out)
    else $error("nop or write length wrong");
  a_read_action_done: assert property (go && act == ACT_READ |=> busy_out [*2] ##1 !busy_out)
    else $error("read action length wrong");
  a_clear_sweep_len: assert property ($fell(busy_out) |-> busy_cnt inside {1, 2, 4097})
    else $error("action length not allowed");
  a_clear_stays_busy: assert property (go && act == ACT_CLEAR |=> busy_out [*8])
    else $error("clear ended early");
  a_cmd_readback: assert property (reg_rd_in && reg_addr_in == OFS_COMMAND
    |=> reg_rdata_out[START_BIT] == $past(busy_out) && reg_rdata_out[6:2] == 5'h00)
    else $error("command byte readback wrong");
  a_sel_rsvd_zero: assert property (reg_rd_in && reg_addr_in == OFS_SELECTOR
    |=> reg_rdata_out[7:4] == 4'h0)
    else $error("selector reserved bits set");
endmodule

bind vta_access vta_access_chk u_chk (.ref_clk_in, .rst_in, .reg_addr_in, .reg_wr_in,
  .reg_wdata_in, .reg_rd_in, .reg_rdata_out, .reg_rvalid_out, .busy_out);

// >>> test/tb_top.sv
`timescale 1ns/1ns
module tb_top;
  import vta_pkg::*;
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin n_fail++; \
  $display("FAIL t=%0t got %h exp %h", $time, (a), (e)); end end

  logic        ref_clk_in          = 1'b0;
  logic        rst_in              = 1'b1;
  logic [15:0] reg_addr_in         = 16'h0000;
  logic        reg_wr_in           = 1'b0;
  logic [7:0]  reg_wdata_in        = 8'h00;
  logic        reg_rd_in           = 1'b0;
  logic [11:0] lookup_index_in     = 12'h000;
  logic [6:0]  lookup_other_map_in = 7'h00;
  logic [7:0]  reg_rdata_out;
  logic        reg_rvalid_out;
  logic        busy_out;
  logic        lookup_valid_out;
  logic        lookup_override_out;
  logic [2:0]  lookup_priority_out;
  logic [2:0]  lookup_spanning_out;
  logic [6:0]  lookup_filter_out;
  logic [6:0]  lookup_untag_out;
  logic [6:0]  lookup_egress_map_out;
  int          n_fail              = 0;
  int          checks              = 0;
  logic [31:0] seed                = 32'h00003E6E;
  logic [31:0] m [0:4095][0:2];
  logic [11:0] idx_q [$];

  vta_access dut (.ref_clk_in, .rst_in, .reg_addr_in, .reg_wr_in, .reg_wdata_in, .reg_rd_in,
    .reg_rdata_out, .reg_rvalid_out, .busy_out, .lookup_index_in, .lookup_other_map_in,
    .lookup_valid_out, .lookup_override_out, .lookup_priority_out, .lookup_spanning_out,
    .lookup_filter_out, .lookup_untag_out, .lookup_egress_map_out);

  // 100 MHz clock
  always #5 ref_clk_in = ~ref_clk_in;

  // Repeatable random source
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Bits of each entry word that survive storage
  function automatic logic [31:0] wmask(input int w);
    return (w == 0) ? MASK_WORD0 : MASK_PORT_MAP;
  endfunction

  task automatic final_report();
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // One byte write, taken at the second edge
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge ref_clk_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge ref_clk_in);
    reg_wr_in <= 1'b0;
  endtask

  // One byte read; the answer is looked at in its only valid cycle
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge ref_clk_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge ref_clk_in);
    reg_rd_in <= 1'b0;
    #1;
    d = reg_rdata_out;
    `CHK(reg_rvalid_out, 1'b1) // Answer strobe
  endtask

  // Big-endian word access
  task automatic wr32(input logic [15:0] a, input logic [31:0] d);
    for (int i = 0; i < 4; i++)
      wr(a + 16'(i), d[31-8*i -: 8]);
  endtask

  task automatic rd32(input logic [15:0] a, output logic [31:0] d);
    logic [7:0] b;
    for (int i = 0; i < 4; i++)
    begin
      rd(a + 16'(i), b);
      d[31-8*i -: 8] = b;
    end
  endtask

  task automatic sel(input logic [11:0] idx);
    wr(OFS_SELECTOR, {4'h0, idx[11:8]});
    wr(OFS_SELECTOR + 16'h0001, idx[7:0]);
  endtask

  // Bounded poll until start clears, then the command byte must show it clear
  task automatic wait_idle(input vta_action_t act);
    logic [7:0] b;
    #1;
    for (int i = 0; i < 5000 && busy_out !== 1'b0; i++)
      @(posedge ref_clk_in) #1;
    `CHK(busy_out, 1'b0) // Self-clearing start
    if (busy_out !== 1'b0)
      final_report();
    rd(OFS_COMMAND, b);
    `CHK(b, {6'h00, act}) // Action kept, start clear
  endtask

  task automatic run(input vta_action_t act);
    wr(OFS_COMMAND, {1'b1, 5'h00, act});
    wait_idle(act); // Poll start low before going on
  endtask

  // Store random contents at one index and keep the masked copy
  task automatic put_entry(input logic [11:0] idx);
    logic [31:0] v;
    for (int w = 0; w < 3; w++)
    begin
      v = rnd();
      wr32(OFS_ENTRY_WORD0 + 16'(4*w), v);
      m[idx][w] = v & wmask(w);
    end
    sel(idx);
    run(ACT_WRITE);
  endtask

  // Look the entry up on the switch side, then read it back through the registers
  task automatic chk_entry(input logic [11:0] idx);
    logic [31:0] v;
    logic [6:0]  om;
    v = rnd();
    om = v[6:0];
    @(posedge ref_clk_in);
    lookup_index_in <= idx;
    lookup_other_map_in <= om;
    repeat (3) @(posedge ref_clk_in);
    #1;
    `CHK(lookup_valid_out, m[idx][0][31]) // Valid flag
    `CHK(lookup_override_out, m[idx][0][27]) // Override flag
    `CHK(lookup_priority_out, m[idx][0][26:24]) // Priority
    `CHK(lookup_spanning_out, m[idx][0][14:12]) // Instance number
    `CHK(lookup_filter_out, m[idx][0][6:0]) // Filter identifier
    `CHK(lookup_untag_out, m[idx][1][6:0]) // Untag map
    `CHK(lookup_egress_map_out, m[idx][0][27] ? m[idx][2][6:0] : om) // Egress choice
    // Junk in the entry registers proves the read really reloads them
    for (int w = 0; w < 3; w++)
      wr32(OFS_ENTRY_WORD0 + 16'(4*w), rnd());
    sel(idx);
    run(ACT_READ);
    for (int w = 0; w < 3; w++)
    begin
      rd32(OFS_ENTRY_WORD0 + 16'(4*w), v);
      `CHK(v, m[idx][w]) // Reloaded word
    end
  endtask

  initial
  begin
    logic [31:0] v;
    logic [31:0] d;
    logic [7:0]  b;
    logic [7:0]  b1;
    logic [11:0] t;
    repeat (16) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    // Every byte reads zero after reset, unmapped neighbours included
    for (int a = 16'h03FF; a <= 16'h0410; a++)
    begin
      rd(a[15:0], b);
      `CHK(b, 8'h00) // Reset value
    end
    $display("test reset_values done");
    // Random bytes everywhere; reserved bits and unmapped bytes stay zero
    for (int r = 0; r < 4; r++)
    begin
      for (int w = 0; w < 3; w++)
      begin
        v = rnd();
        wr32(OFS_ENTRY_WORD0 + 16'(4*w), v);
        rd32(OFS_ENTRY_WORD0 + 16'(4*w), d);
        `CHK(d, v & wmask(w)) // Field layout
      end
      v = rnd();
      wr(OFS_SELECTOR, v[15:8]);
      wr(OFS_SELECTOR + 16'h0001, v[7:0]);
      rd(OFS_SELECTOR, b1);
      rd(OFS_SELECTOR + 16'h0001, b);
      `CHK({b1, b}, v[15:0] & MASK_SELECTOR) // Selector width
      wr(OFS_COMMAND, {1'b0, v[22:16]});
      rd(OFS_COMMAND, b);
      `CHK(b, {6'h00, v[17:16]}) // Action stored, no start
      wr(16'h040F, v[7:0]);
      rd(16'h040F, b);
      `CHK(b, 8'h00) // Unmapped byte
    end
    $display("test masks done");
    // Entries at both ends of the table and at random places
    idx_q = '{12'h000, 12'hFFF};
    for (int i = 0; i < 4; i++)
    begin
      v = rnd();
      idx_q.push_back(v[11:0]);
    end
    foreach (idx_q[i])
      put_entry(idx_q[i]);
    foreach (idx_q[i])
      chk_entry(idx_q[i]);
    $display("test write_read done");
    // A no-op leaves the table alone; a write landing while busy is dropped
    t = idx_q[$];
    for (int w = 0; w < 3; w++)
      wr32(OFS_ENTRY_WORD0 + 16'(4*w), rnd());
    run(ACT_NOP);
    // A no-op is busy for one cycle only; a read holds start long enough to drop the next write
    wr(OFS_COMMAND, 8'h82);
    wr(OFS_SELECTOR + 16'h0001, ~t[7:0]);
    wait_idle(ACT_READ);
    rd(OFS_SELECTOR + 16'h0001, b);
    `CHK(b, t[7:0]) // Write ignored while busy
    chk_entry(t); // Table untouched by no-op
    $display("test nop_busy done");
    // Clear-all from a random selector; a second start during the sweep is dropped
    v = rnd();
    sel(v[11:0]);
    idx_q.push_back(v[11:0]); // Likely never written, so only the sweep zeroes it
    wr(OFS_COMMAND, 8'h83);
    wr(OFS_COMMAND, 8'h81);
    wait_idle(ACT_CLEAR); // Sweep ends with action unchanged
    foreach (idx_q[i])
      for (int w = 0; w < 3; w++)
        m[idx_q[i]][w] = 32'h00000000;
    foreach (idx_q[i])
      chk_entry(idx_q[i]); // Every entry in idx_q reads zero
    $display("test clear_all done");
    final_report();
  end
endmodule
